//--- pmf_defines.svh
// constants of the preamp mode and fault control block
// assumes a 100 MHz system clock
`ifndef PMF_DEFINES_SVH
`define PMF_DEFINES_SVH
`define PMF_CLK_MHZ 100
`define PMF_FRAME_BITS 16
`define PMF_REG_HS 4'h0
`define PMF_REG_CFG 4'h1
`define PMF_REG_BW 4'h3
`define PMF_REG_WR 4'h4
`define PMF_REG_TA 4'h5
`define PMF_REG_ID 4'h6
`define PMF_REG_FLT 4'h7
`define PMF_REG_MEAS 4'h8
`define PMF_REG_MODE 4'h9
`define PMF_REG_OVS 4'he
`define PMF_REG_ASPERITY_SHUTDOWN 4'hf
`define PMF_B_MULTI_SELECT_TEST 3
`define PMF_B_FAST_PIN_FUNCTION 0
`define PMF_B_TAD 6
`define PMF_B_TAC 5
`define PMF_B_TMF 5
`define PMF_B_MRR 4
`define PMF_B_RSTDMY 2
`define PMF_B_OVERSHOOT_ENABLE 2
`define PMF_B_ASPERITY_SHUTDOWN 7
`define PMF_F_NONE 4'h0
`define PMF_F_ILLHEAD 4'hd
`define PMF_F_MDS 4'he
`define PMF_F_SUPPLY 4'hb
`define PMF_TA_HOLD_NS 1500
`define PMF_TA_HOLD_CYC ((`PMF_TA_HOLD_NS * `PMF_CLK_MHZ + 999) / 1000)
`define PMF_MEAS_US 800
`define PMF_MEAS_CYC (`PMF_MEAS_US * `PMF_CLK_MHZ)
`endif

//--- pmf_pkg.sv
// types of the preamp mode and fault control block
// assumes nothing of its surroundings
package pmf_pkg;
	typedef enum logic [1:0] {PMF_SLEEP, PMF_IDLE, PMF_RW, PMF_ROUTON} pmf_mode_t;
	typedef enum {PMF_M_IDLE, PMF_M_RUN, PMF_M_HOLD} pmf_meas_t;
endpackage

//--- pmf_control.sv
// preamp mode and fault control: serial port, head decode, fault latch,
// asperity bandwidth control and triggered measurements
// assumes analog sensing and measurement values come in as levels
`timescale 1ns/1ns
`include "pmf_defines.svh"
module pmf_control import pmf_pkg::*; #(
	parameter int MEAS_CYC = `PMF_MEAS_CYC,
	parameter logic [7:0] VENDOR_ID = 8'h5a // arbitrary value
) (
	input wire logic sys_clk, // system clock
	input wire logic rst, // synchronous reset
	input wire logic sclk, // serial clock pin
	input wire logic sdata_in, // serial data pin in
	output logic sdata_out, // serial data pin out
	output logic sdata_oe, // serial data drive enable
	input wire logic serial_data_enable, // frame enable pin
	input wire logic [1:0] chip_select_pins, // device address pins
	input wire logic rw_pin, // 1 read, 0 write
	input wire logic servo_write_select_pin, // low allows broadcast
	input wire logic reset_pin_n, // reset or dummy pin
	input wire logic fast_recovery_pin, // fast corner or bias pin
	input wire logic [15:0] fault_sense, // present faults by code
	input wire logic asperity_sense, // asperity above threshold
	input wire logic multi_select_sense, // unsafe line below third
	input wire logic [6:0] resistance_value, // head resistance code
	input wire logic [6:0] temperature_value, // die temperature code
	output logic [5:0] head_enable, // selected write/read heads
	output logic write_current_on, // write current enabled
	output logic read_on, // read path enabled
	output logic [2:0] overshoot_level, // applied overshoot code
	output logic overshoot_on, // overshoot programming active
	output logic head_unsafe_output, // fault present indication
	output logic head_unsafe_mid, // selection test mid level
	output logic low_corner_fast, // low corner at 8 MHz
	output logic [1:0] low_corner_select, // programmed low corner
	output logic asperity_shutdown, // asperity circuit off
	output logic bias_off, // head bias gated off
	output logic servo_write_active, // servo track write mode
	output logic routon_active, // read during write
	output logic [3:0] fault_code // latched fault code
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [5:0] s1, s2;
	logic sclk_d, serial_data_enable_d;
	always_ff @(posedge sys_clk) begin
		s1 <= {sclk, sdata_in, serial_data_enable, servo_write_select_pin, reset_pin_n, fast_recovery_pin};
		s2 <= s1;
		sclk_d <= s2[5];
		serial_data_enable_d <= s2[3];
	end
	wire sclk_s = s2[5];
	wire sdat_s = s2[4];
	wire serial_data_enable_s = s2[3];
	wire stw_pin = s2[2];
	wire rstp_n = s2[1];
	wire fast_pin = s2[0];
	wire sclk_rise = sclk_s & ~sclk_d;
	wire sclk_fall = ~sclk_s & sclk_d;
	wire serial_data_enable_fall = ~serial_data_enable_s & serial_data_enable_d;

	logic [7:0] regs [0:15];
	wire dev_rst = rst | (~rstp_n & ~regs[`PMF_REG_MODE][`PMF_B_RSTDMY]);

	// ----------------------------------------------------------------
	// serial frame
	// ----------------------------------------------------------------
	logic [15:0] shreg;
	logic [4:0] bitcnt;
	always_ff @(posedge sys_clk) begin
		if (dev_rst || (serial_data_enable_s && !serial_data_enable_d)) begin
			bitcnt <= 5'h0;
		end else if (serial_data_enable_s && sclk_rise) begin
			shreg <= {sdat_s, shreg[15:1]}; // lsb first
			if (bitcnt != 5'h11)
				bitcnt <= bitcnt + 5'h1;
		end
	end
	wire frame_ok = serial_data_enable_fall && bitcnt == 5'h10;
	wire f_rd = shreg[0];
	wire [1:0] f_cs = {shreg[2], shreg[1]};
	wire [3:0] f_addr = shreg[6:3];
	wire [7:0] f_data = shreg[15:8];
	wire bcast = f_cs == 2'h3;
	// broadcast ignores the pins only with the select pin low
	wire hit = bcast ? ~stw_pin : (f_cs == chip_select_pins);
	wire wr_go = frame_ok && !f_rd && hit && f_addr != `PMF_REG_ID && f_addr != `PMF_REG_MEAS;
	wire mode_wr = wr_go && f_addr == `PMF_REG_MODE;

	// ----------------------------------------------------------------
	// modes
	// ----------------------------------------------------------------
	logic stw_flag;
	always_ff @(posedge sys_clk) begin
		if (dev_rst)
			stw_flag <= 1'b0;
		else if (frame_ok && !bcast)
			stw_flag <= 1'b0;
		else if (frame_ok && hit && !rw_pin)
			stw_flag <= 1'b1;
	end
	pmf_mode_t mode;
	assign mode = pmf_mode_t'(regs[`PMF_REG_MODE][1:0]);
	wire meas_bits = regs[`PMF_REG_MODE][`PMF_B_MRR] | regs[`PMF_REG_MODE][`PMF_B_TMF];
	assign servo_write_active = stw_flag && mode[1] && !stw_pin && !rw_pin && !meas_bits;
	assign routon_active = mode == PMF_ROUTON && stw_pin && !rw_pin && !servo_write_active;
	wire rw_mode = mode[1] && !servo_write_active && !meas_bits;
	wire rd_mode = rw_mode && rw_pin;
	wire wr_mode = rw_mode && !rw_pin;

	// ----------------------------------------------------------------
	// head select decode
	// ----------------------------------------------------------------
	wire grp = regs[`PMF_REG_HS][7];
	wire [2:0] k = regs[`PMF_REG_HS][6:4];
	wire illegal_head = rw_mode && (k > 3'h5 || grp);
	logic [5:0] hsel;
	always_comb begin
		hsel = 6'h00;
		if (servo_write_active) begin
			if (!mode[0]) begin
				if (!grp)
					hsel = (k <= 3'h5) ? 6'h01 << k : 6'h00;
				else if (k <= 3'h2)
					hsel = 6'h07;
				else if (k <= 3'h5)
					hsel = 6'h38;
			end else begin
				if (grp)
					hsel = 6'h3f;
				else if (k <= 3'h5)
					hsel = (6'h03 << k) & 6'h3f;
			end
		end else if (rw_mode && !illegal_head) begin
			hsel = 6'h01 << k;
		end
	end
	assign head_enable = hsel;

	// ----------------------------------------------------------------
	// fault detection and latch
	// ----------------------------------------------------------------
	function automatic logic [3:0] rank(input logic [3:0] c);
		case (c)
			4'hb: rank = 4'd1;
			4'h9: rank = 4'd2;
			4'hd: rank = 4'd3;
			4'h8: rank = 4'd4;
			4'ha: rank = 4'd5;
			4'h6: rank = 4'd6;
			4'hf: rank = 4'd7;
			4'h2: rank = 4'd8;
			4'h5: rank = 4'd9;
			4'h1: rank = 4'd10;
			4'h4: rank = 4'd11;
			4'he: rank = 4'd12;
			4'h3: rank = 4'd13;
			4'h7: rank = 4'd14;
			default: rank = 4'd15;
		endcase
	endfunction
	function automatic logic masked(input logic [3:0] c, input logic [3:0] m);
		case (c)
			4'h7, 4'h9, 4'ha: masked = m[3];
			4'h6, 4'h2: masked = m[2];
			4'hf, 4'h4: masked = m[1];
			4'he, 4'h3, 4'h8: masked = m[0];
			default: masked = 1'b0;
		endcase
	endfunction
	wire [3:0] fmask = regs[`PMF_REG_FLT][7:4];
	wire multi_select_test = regs[`PMF_REG_HS][`PMF_B_MULTI_SELECT_TEST] && !servo_write_active;
	wire ta_flag_en = !regs[`PMF_REG_ASPERITY_SHUTDOWN][`PMF_B_ASPERITY_SHUTDOWN] && (regs[`PMF_REG_TA][`PMF_B_TAD]
		|| regs[`PMF_REG_TA][`PMF_B_TAC]);
	logic [15:0] present;
	logic [3:0] best;
	always_comb begin
		present = fault_sense;
		present[0] = 1'b0;
		present[12] = 1'b0; // unassigned
		present[14] = 1'b0;
		present[`PMF_F_ILLHEAD] = illegal_head;
		present[3] = fault_sense[3] | asperity_sense;
		if (!ta_flag_en)
			present[3] = 1'b0;
		if (!rw_mode || multi_select_test)
			present = 16'h0000;
		best = `PMF_F_NONE;
		for (int i = 1; i < 16; i++) begin
			if (present[i] && !masked(4'(i), fmask) && rank(4'(i)) < rank(best))
				best = 4'(i);
		end
	end
	logic mds_hit, multi_select_flag_flag;
	assign mds_hit = multi_select_test && multi_select_sense && !fmask[0];
	always_ff @(posedge sys_clk) begin
		if (dev_rst) begin
			fault_code <= `PMF_F_NONE;
			multi_select_flag_flag <= 1'b0;
		end else if (mds_hit || multi_select_flag_flag) begin
			fault_code <= `PMF_F_MDS;
			multi_select_flag_flag <= 1'b1;
		end else if (best != `PMF_F_NONE && (mode_wr || rank(best) < rank(fault_code))) begin
			fault_code <= best;
		end else if (mode_wr) begin
			fault_code <= `PMF_F_NONE;
		end
	end
	assign head_unsafe_output = best != `PMF_F_NONE;
	assign head_unsafe_mid = multi_select_test;
	assign write_current_on = wr_mode && !illegal_head && !fault_sense[`PMF_F_SUPPLY];
	assign read_on = (rd_mode || routon_active) && !illegal_head;
	assign overshoot_on = regs[`PMF_REG_OVS][`PMF_B_OVERSHOOT_ENABLE];
	assign overshoot_level = overshoot_on ? regs[`PMF_REG_WR][2:0] : 3'h0;

	// ----------------------------------------------------------------
	// asperity bandwidth control
	// ----------------------------------------------------------------
	localparam int TA_HOLD = `PMF_TA_HOLD_CYC;
	logic [7:0] ta_hold;
	wire auto_ta = !asperity_shutdown && regs[`PMF_REG_TA][`PMF_B_TAC];
	wire fast_pin_function = regs[`PMF_REG_CFG][`PMF_B_FAST_PIN_FUNCTION];
	always_ff @(posedge sys_clk) begin
		if (dev_rst || !auto_ta)
			ta_hold <= 8'h00;
		else if (asperity_sense)
			ta_hold <= 8'(TA_HOLD);
		else if (ta_hold != 8'h00)
			ta_hold <= ta_hold - 8'h01;
	end
	assign asperity_shutdown = regs[`PMF_REG_ASPERITY_SHUTDOWN][`PMF_B_ASPERITY_SHUTDOWN];
	always_comb begin
		if (asperity_shutdown)
			low_corner_fast = 1'b0;
		else if (auto_ta)
			low_corner_fast = asperity_sense || ta_hold != 8'h00;
		else
			low_corner_fast = fast_pin_function && fast_pin;
	end
	assign low_corner_select = regs[`PMF_REG_BW][1:0];
	assign bias_off = !fast_pin_function && fast_pin;

	// ----------------------------------------------------------------
	// measurements
	// ----------------------------------------------------------------
	pmf_meas_t mstate;
	logic [16:0] mcnt;
	logic mtemp;
	logic [6:0] mresult;
	wire resistance_measure_enable = regs[`PMF_REG_MODE][`PMF_B_MRR];
	wire temperature_measure_enable = regs[`PMF_REG_MODE][`PMF_B_TMF];
	wire mrr_rd = resistance_measure_enable && mode == PMF_RW && rw_pin && stw_pin;
	always_ff @(posedge sys_clk) begin
		if (dev_rst) begin
			mstate <= PMF_M_IDLE;
			mcnt <= 17'h0;
			mtemp <= 1'b0;
			mresult <= 7'h00;
		end else begin
			case (mstate)
				PMF_M_IDLE: begin
					if (temperature_measure_enable || mrr_rd) begin
						mstate <= PMF_M_RUN;
						mtemp <= temperature_measure_enable;
						mcnt <= 17'(MEAS_CYC - 1);
					end
				end
				PMF_M_RUN: begin
					if (mtemp ? !temperature_measure_enable : !mrr_rd) begin
						mstate <= PMF_M_IDLE; // valid only if held
					end else if (mcnt == 17'h0) begin
						mresult <= mtemp ? temperature_value : resistance_value;
						mstate <= PMF_M_HOLD;
					end else begin
						mcnt <= mcnt - 17'h1;
					end
				end
				PMF_M_HOLD: begin
					if (!temperature_measure_enable && !resistance_measure_enable)
						mstate <= PMF_M_IDLE;
				end
				default: mstate <= PMF_M_IDLE;
			endcase
		end
	end
	// the counter is 17 bits wide
	if (MEAS_CYC < 1 || MEAS_CYC > 131071) begin : g_bad_meas
		$error("measurement count out of range");
	end

	// ----------------------------------------------------------------
	// register file and readback
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (dev_rst) begin
			for (int i = 0; i < 16; i++)
				regs[i] <= 8'h00;
		end else if (wr_go) begin
			regs[f_addr] <= f_data;
		end
	end
	// after eight bits the header sits in the upper half of the shifter
	wire hit_rd = (shreg[10:9] == 2'h3) ? ~stw_pin : (shreg[10:9] == chip_select_pins);
	logic [3:0] rd_addr;
	// the header keeps shifting during readback, so hold its address
	wire [3:0] rd_sel = (bitcnt == 5'h8) ? shreg[14:11] : rd_addr;
	logic [7:0] rdata;
	always_comb begin
		case (rd_sel)
			`PMF_REG_HS: rdata = {regs[0][7:3], multi_select_flag_flag, chip_select_pins};
			`PMF_REG_ID: rdata = VENDOR_ID;
			`PMF_REG_FLT: rdata = {fmask, fault_code};
			`PMF_REG_MEAS: rdata = {1'b0, mresult};
			default: rdata = regs[rd_sel];
		endcase
	end
	logic rd_act;
	always_ff @(posedge sys_clk) begin
		if (dev_rst || !serial_data_enable_s) begin
			rd_act <= 1'b0;
			rd_addr <= 4'h0;
			sdata_out <= 1'b0;
		end else if (sclk_fall && bitcnt >= 5'h8 && bitcnt < 5'h10) begin
			if (bitcnt == 5'h8) begin
				rd_act <= shreg[8] && hit_rd;
				rd_addr <= shreg[14:11];
			end
			sdata_out <= rdata[bitcnt[2:0]];
		end
	end
	assign sdata_oe = rd_act;
endmodule

//--- pmf_ctrl_model.sv
// drive controller model on the three-wire serial port
// assumes calls start on a falling system clock edge
`timescale 1ns/1ns
module pmf_ctrl_model (
	output logic sclk, // serial clock, still between frames
	output logic sdata, // serial data to the device
	output logic sen, // frame enable
	input wire logic sdata_back // readback from the device
);
	logic [7:0] rdata;
	initial begin
		sclk = 0;
		sdata = 0;
		sen = 0;
	end
	// ---------------------------------------------------------
	// one frame, lsb first, 160 ns serial clock
	// ---------------------------------------------------------
	task automatic send(input logic [15:0] w, input int n);
		sen = 1;
		#80;
		for (int i = 0; i < n; i++) begin
			sdata = w[i];
			#80 sclk = 1;
			if (i > 7) rdata[i-8] = sdata_back;
			#80 sclk = 0;
		end
		#80 sen = 0;
		sdata = ~sdata;
		#160;
	endtask
endmodule

//--- pmf_control_sva.sv
// checker on the ports of the mode and fault control block
// assumes a bind onto pmf_control, one clock domain
`timescale 1ns/1ns
module pmf_control_sva import pmf_pkg::*; #(
	parameter int MEAS_CYC = 20
) (
	input wire logic sys_clk, // clock
	input wire logic rst, // sync reset
	input wire logic fast_recovery_pin, // fast pin
	input wire logic asperity_sense, // asperity in
	input wire logic [5:0] head_enable, // heads
	input wire logic [2:0] overshoot_level, // overshoot code
	input wire logic overshoot_on, // overshoot on
	input wire logic head_unsafe_mid, // test level
	input wire logic low_corner_fast, // fast corner
	input wire logic asperity_shutdown, // asperity off
	input wire logic servo_write_active, // servo write
	input wire logic routon_active, // read in write
	input wire logic [3:0] fault_code // latched code
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ---------------------------------------------------------
	// properties
	// ---------------------------------------------------------
	sequence ta_ends;
		low_corner_fast && !fast_recovery_pin && !$past(fast_recovery_pin, 4) && $fell(asperity_sense);
	endsequence
	sequence fast_held;
		low_corner_fast [*8];
	endsequence
	ta_hold_a: assert property (ta_ends |=> fast_held)
		else $error("low corner released early");
	ovs_gate_a: assert property (!overshoot_on |-> overshoot_level == 3'h0)
		else $error("overshoot applied while off");
	code_unused_a: assert property (fault_code != 4'hc)
		else $error("unassigned fault code");
	code_clear_a: assert property (disable iff (1'b0) rst |=> fault_code == 4'h0)
		else $error("fault code kept over reset");
	routon_one_a: assert property (routon_active |-> $onehot0(head_enable) && !servo_write_active)
		else $error("read during write head count");
	stw_mds_a: assert property (servo_write_active && fault_code != 4'he |=> fault_code != 4'he)
		else $error("multi select fault in servo write");
	stw_mid_a: assert property (servo_write_active |-> !head_unsafe_mid)
		else $error("selection test in servo write");
	shut_slow_a: assert property (asperity_shutdown |-> !low_corner_fast)
		else $error("fast corner while shut down");
endmodule

//--- test_pmf_control.sv
// self-checking bench of the preamp mode and fault control block
// assumes pmf_control, its checker and the controller model
`timescale 1ns/1ns
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
	$display("MISMATCH %0t got %0h exp %0h", $time, a, e); end end
module test_pmf_control import pmf_pkg::*;;
	logic sys_clk, rst, sclk, sdata_in, sdata_out, sdata_oe, serial_data_enable, rw_pin, servo_write_select_pin;
	logic reset_pin_n, fast_recovery_pin, asperity_sense, multi_select_sense, write_current_on, read_on;
	logic overshoot_on, head_unsafe_output, head_unsafe_mid, low_corner_fast, asperity_shutdown, bias_off;
	logic servo_write_active, routon_active;
	logic [1:0] chip_select_pins, low_corner_select;
	logic [15:0] fault_sense;
	logic [6:0] resistance_value, temperature_value;
	logic [5:0] head_enable;
	logic [2:0] overshoot_level;
	logic [3:0] fault_code;
	int mismatches = 0, num_checks = 0, cyc = 0;
	logic [21:0] stw [6] = '{{8'h02, 8'h30, 6'h08}, {8'h02, 8'h90, 6'h07}, {8'h02, 8'hc0, 6'h38},
		{8'h03, 8'h40, 6'h30}, {8'h03, 8'h50, 6'h20}, {8'h03, 8'h80, 6'h3f}};
	logic [19:0] pt [8] = '{{16'h0a00, 4'hb}, {16'h0600, 4'h9}, {16'h8400, 4'ha}, {16'h8004, 4'hf},
		{16'h0006, 4'h2}, {16'h0012, 4'h1}, {16'h0090, 4'h4}, {16'h0080, 4'h7}};
	logic [23:0] mt [5] = '{{4'h8, 16'h0680, 4'h0}, {4'h4, 16'h0044, 4'h0}, {4'h2, 16'h8010, 4'h0},
		{4'h1, 16'h0100, 4'h0}, {4'h9, 16'h0202, 4'h1}};
	pmf_control #(.MEAS_CYC(20)) u_pmf_control (.*);
	pmf_ctrl_model u_pmf_ctrl_model (.sclk(sclk), .sdata(sdata_in), .sen(serial_data_enable), .sdata_back(sdata_out));
	// ---------------------------------------------------------
	// clock, timeout, access tasks
	// ---------------------------------------------------------
	initial begin
		sys_clk = 0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic close_out();
		if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 50000) begin
			mismatches++;
			close_out();
		end
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] cs = 2'b01);
		u_pmf_ctrl_model.send({d, 1'b0, a, cs, 1'b0}, 16);
	endtask
	task automatic meas(input logic [6:0] e);
		u_pmf_ctrl_model.send({8'h00, 1'b0, 4'h8, 2'b01, 1'b1}, 16);
		`CHK(u_pmf_ctrl_model.rdata[6:0], e)
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	initial begin
		rst = 1;
		rw_pin = 0;
		servo_write_select_pin = 0;
		reset_pin_n = 1;
		fast_recovery_pin = 0;
		asperity_sense = 0;
		multi_select_sense = 0;
		chip_select_pins = 2'b01;
		fault_sense = 16'h0000;
		resistance_value = 7'h2b;
		temperature_value = 7'h11;
		wt(4);
		rst = 0;
		wt(1);
		`CHK(fault_code, 4'h0)
		foreach (stw[i]) begin
			wr(4'h9, stw[i][21:14], 2'b11);
			wr(4'h0, stw[i][13:6], 2'b11);
			`CHK(servo_write_active, 1'b1)
			`CHK(head_enable, stw[i][5:0])
		end
		multi_select_sense = 1;
		wr(4'h0, 8'h88, 2'b11);
		`CHK(head_unsafe_mid, 1'b0)
		`CHK(fault_code, 4'h0)
		multi_select_sense = 0;
		wr(4'h4, 8'h00);
		`CHK(servo_write_active, 1'b0)
		wr(4'h0, 8'h10, 2'b11);
		servo_write_select_pin = 1;
		wt(5);
		`CHK(routon_active, 1'b1)
		rw_pin = 1;
		wr(4'h9, 8'h02);
		multi_select_sense = 1;
		wr(4'h0, 8'h08);
		`CHK(head_unsafe_mid, 1'b1)
		`CHK(fault_code, 4'he)
		multi_select_sense = 0;
		wr(4'h9, 8'h02);
		`CHK(fault_code, 4'he)
		reset_pin_n = 0;
		wt(6);
		reset_pin_n = 1;
		wt(6);
		`CHK(fault_code, 4'h0)
		wr(4'he, 8'h04, 2'b11);
		`CHK(overshoot_on, 1'b0)
		u_pmf_ctrl_model.send({8'h04, 1'b0, 4'he, 2'b01, 1'b0}, 15);
		`CHK(overshoot_on, 1'b0)
		wr(4'h4, 8'h05);
		wr(4'he, 8'h04);
		`CHK(overshoot_level, 3'h5)
		wr(4'he, 8'h00);
		`CHK(overshoot_level, 3'h0)
		wr(4'h9, 8'h02);
		foreach (pt[i]) begin
			fault_sense = pt[i][19:4];
			wt(3);
			`CHK(fault_code, pt[i][3:0])
			`CHK(head_unsafe_output, 1'b1)
			fault_sense = 16'h0000;
			wt(2);
			`CHK(head_unsafe_output, 1'b0)
			wr(4'h9, 8'h02);
			`CHK(fault_code, 4'h0)
		end
		foreach (mt[i]) begin
			wr(4'h7, {mt[i][23:20], 4'h0});
			fault_sense = mt[i][19:4];
			wt(3);
			`CHK(fault_code, mt[i][3:0])
			fault_sense = 16'h0000;
			wr(4'h9, 8'h02);
		end
		wr(4'h7, 8'h00);
		wr(4'h0, 8'h60);
		`CHK(head_enable, 6'h00)
		`CHK(read_on, 1'b0)
		`CHK(fault_code, 4'hd)
		wr(4'h0, 8'h10);
		`CHK(head_enable, 6'h02)
		rw_pin = 0;
		wr(4'h9, 8'h02);
		`CHK(write_current_on, 1'b1)
		fault_sense = 16'h0800;
		wt(3);
		`CHK(write_current_on, 1'b0)
		`CHK(fault_code, 4'hb)
		fault_sense = 16'h0000;
		wt(3);
		`CHK(write_current_on, 1'b1)
		`CHK(head_unsafe_output, 1'b0)
		rw_pin = 1;
		wr(4'h1, 8'h01);
		fast_recovery_pin = 1;
		wt(5);
		`CHK(low_corner_fast, 1'b1)
		fast_recovery_pin = 0;
		wt(5);
		`CHK(low_corner_fast, 1'b0)
		wr(4'h1, 8'h00);
		fast_recovery_pin = 1;
		wt(5);
		`CHK(bias_off, 1'b1)
		fast_recovery_pin = 0;
		wr(4'h5, 8'h20);
		wr(4'h9, 8'h02);
		asperity_sense = 1;
		wt(3);
		`CHK(low_corner_fast, 1'b1)
		`CHK(fault_code, 4'h3)
		asperity_sense = 0;
		wt(140);
		`CHK(low_corner_fast, 1'b1)
		wt(20);
		`CHK(low_corner_fast, 1'b0)
		wr(4'hf, 8'h80);
		asperity_sense = 1;
		wt(3);
		`CHK(asperity_shutdown, 1'b1)
		`CHK(low_corner_fast, 1'b0)
		asperity_sense = 0;
		wr(4'h9, 8'h12);
		wt(40);
		meas(7'h2b);
		wr(4'h8, 8'h7f);
		meas(7'h2b);
		wr(4'h9, 8'h02);
		wr(4'h9, 8'h22);
		wt(40);
		meas(7'h11);
		close_out();
	end
endmodule
bind pmf_control pmf_control_sva #(.MEAS_CYC(MEAS_CYC)) u_pmf_control_sva (.*);
